// file: include/ptb_regs.svh
`ifndef PTB_REGS_SVH
`define PTB_REGS_SVH
// register byte offsets in the controller space
`define PTB_OFF_MW0_UPPER 16'hd014
`define PTB_OFF_MW1_LOWER 16'hd018
`define PTB_OFF_MW1_UPPER 16'hd01c
`define PTB_OFF_MW2_BASE 16'hd020
`define PTB_OFF_IO_BASE 16'hd024
// matching configuration header offsets
`define PTB_CFG_MW1 8'h18
`define PTB_CFG_MW2 8'h20
`define PTB_CFG_IO 8'h24
// base field widths: 16 MB, 1 MB, 256 byte windows
`define PTB_MW1_BITS 8
`define PTB_MW2_BITS 12
`define PTB_IO_BITS 24
// fixed low bits
`define PTB_MW1_LOW 4'h8
`define PTB_MW2_LOW 4'h0
`define PTB_IO_LOW 8'h01
`define PTB_BASE_RESET 32'h0000_0000
`endif

// file: include/ptb_pkg.sv
`default_nettype none
package ptb_pkg;
  typedef enum logic [1:0] {
    PTB_ACC_MEM = 2'h1,
    PTB_ACC_IO = 2'h2
  } ptb_acc_e;
endpackage
`default_nettype wire

// file: logic/ptb_decode.sv
`include "ptb_regs.svh"
`default_nettype none
// window hit compare: upper address bits against programmed base
module ptb_decode #(
  parameter int W = 8
) (
  input wire logic [31:0] i_addr,
  input wire logic [W-1:0] i_base,
  output logic o_hit
);
  assign o_hit = (i_addr[31 -: W] == i_base);
endmodule
`default_nettype wire

// file: logic/ptb_bar_regs.sv
// Contract
// - no dual-address cycles; upper registers unused
// - window one base 31:24, reset zero
// - window one prefetchable flag reads one
// - memory type bits read zero
// - memory space indicator reads zero
// - window two base 31:20, reset zero
// - window two prefetchable flag reads zero
// - I/O base 31:8, reset zero
// - I/O space indicator reads one
// - header offsets 0x18, 0x20, 0x24
// - bits between base and flags reserved
`include "ptb_regs.svh"
`default_nettype none
module ptb_bar_regs
  import ptb_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_cfg,
  input wire logic [15:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_dac,
  input wire logic i_tgt_valid,
  input wire logic [1:0] i_tgt_type,
  input wire logic [31:0] i_tgt_addr,
  output logic [31:0] o_rdata,
  output logic o_rvalid,
  output logic o_claim_mw1,
  output logic o_claim_mw2,
  output logic o_claim_io
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [`PTB_MW1_BITS-1:0] mw1;
    logic [`PTB_MW2_BITS-1:0] mw2;
    logic [`PTB_IO_BITS-1:0] io;
    logic [31:0] rdata;
    logic rvalid;
    logic c1;
    logic c2;
    logic cio;
  } ptb_state_s;
  ptb_state_s st_ff, nxt_st;
  logic h1, h2, hio;
  logic [2:0] sel;

  // map either controller offset or header offset to a register select
  function automatic logic [2:0] ptb_sel(input logic cfg,
                                         input logic [15:0] a);
    logic [2:0] s;
    s = 3'h0;
    if (cfg)
    begin
      if (a[7:0] == `PTB_CFG_MW1) s = 3'h1;
      else if (a[7:0] == `PTB_CFG_MW2) s = 3'h2;
      else if (a[7:0] == `PTB_CFG_IO) s = 3'h3;
    end
    else
    begin
      if (a == `PTB_OFF_MW1_LOWER) s = 3'h1;
      else if (a == `PTB_OFF_MW2_BASE) s = 3'h2;
      else if (a == `PTB_OFF_IO_BASE) s = 3'h3;
    end
    return s;
  endfunction

  ptb_decode #(.W(`PTB_MW1_BITS)) u_d1 (
    .i_addr(i_tgt_addr), .i_base(st_ff.mw1), .o_hit(h1));
  ptb_decode #(.W(`PTB_MW2_BITS)) u_d2 (
    .i_addr(i_tgt_addr), .i_base(st_ff.mw2), .o_hit(h2));
  ptb_decode #(.W(`PTB_IO_BITS)) u_d3 (
    .i_addr(i_tgt_addr), .i_base(st_ff.io), .o_hit(hio));

  assign sel = ptb_sel(i_cfg, i_addr);

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rvalid = i_rd;
    nxt_st.rdata = 32'h0000_0000;
    // only base fields take write data
    if (i_wr)
    begin
      case (sel)
        3'h1: nxt_st.mw1 = i_wdata[31 -: `PTB_MW1_BITS];
        3'h2: nxt_st.mw2 = i_wdata[31 -: `PTB_MW2_BITS];
        3'h3: nxt_st.io = i_wdata[31 -: `PTB_IO_BITS];
        // upper registers and others have no effect
        default: ;
      endcase
    end
    if (i_rd)
    begin
      case (sel)
        3'h1: nxt_st.rdata = {st_ff.mw1, 20'h0_0000, `PTB_MW1_LOW};
        3'h2: nxt_st.rdata = {st_ff.mw2, 16'h0000, `PTB_MW2_LOW};
        3'h3: nxt_st.rdata = {st_ff.io, `PTB_IO_LOW};
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end
    // claim on type and base match, never for dual address
    nxt_st.c1 = i_tgt_valid && !i_dac && i_tgt_type == PTB_ACC_MEM && h1;
    nxt_st.c2 = i_tgt_valid && !i_dac && i_tgt_type == PTB_ACC_MEM && h2;
    nxt_st.cio = i_tgt_valid && !i_dac && i_tgt_type == PTB_ACC_IO && hio;
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign o_rdata = st_ff.rdata;
  assign o_rvalid = st_ff.rvalid;
  assign o_claim_mw1 = st_ff.c1;
  assign o_claim_mw2 = st_ff.c2;
  assign o_claim_io = st_ff.cio;

  // ****************************************
  // checks
  // ****************************************
  property p_mw1_flags;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_rd && sel == 3'h1) |=> o_rdata[23:0] == 24'h00_0008;
  endproperty
  a_mw1_flags: assert property (p_mw1_flags)
    else $error("window one low bits wrong");
  property p_mw2_flags;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_rd && sel == 3'h2) |=> o_rdata[19:0] == 20'h0_0000;
  endproperty
  a_mw2_flags: assert property (p_mw2_flags)
    else $error("window two low bits wrong");
  property p_io_flags;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_rd && sel == 3'h3) |=> o_rdata[7:0] == 8'h01;
  endproperty
  a_io_flags: assert property (p_io_flags)
    else $error("io low bits wrong");
  property p_mw1_wr;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_wr && !i_rd && sel == 3'h1) ##1 (i_rd && !i_wr && sel == 3'h1)
      |=> o_rdata[31:24] == $past(i_wdata[31:24], 2);
  endproperty
  a_mw1_wr: assert property (p_mw1_wr)
    else $error("window one base not stored");
  property p_mw2_wr;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_wr && sel == 3'h2) |=> st_ff.mw2 == $past(i_wdata[31:20]);
  endproperty
  a_mw2_wr: assert property (p_mw2_wr)
    else $error("window two base not stored");
  property p_io_wr;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_wr && sel == 3'h3) |=> st_ff.io == $past(i_wdata[31:8]);
  endproperty
  a_io_wr: assert property (p_io_wr)
    else $error("io base not stored");
  property p_upper;
    @(posedge i_clk) disable iff (!i_reset_n)
    (sel == 3'h0) |=> $stable(st_ff.mw1) && $stable(st_ff.mw2)
      && $stable(st_ff.io);
  endproperty
  a_upper: assert property (p_upper)
    else $error("unmapped write changed a base");
  property p_claim;
    @(posedge i_clk) disable iff (!i_reset_n)
    o_claim_io |-> $past(i_tgt_type) == PTB_ACC_IO
      && $past(i_tgt_addr[31:8]) == $past(st_ff.io) && !$past(i_dac);
  endproperty
  a_claim: assert property (p_claim)
    else $error("io claim without match");
  property p_mw1_claim;
    @(posedge i_clk) disable iff (!i_reset_n)
    o_claim_mw1 |-> $past(i_tgt_valid) && !$past(i_dac)
      && $past(i_tgt_type) == PTB_ACC_MEM
      && $past(i_tgt_addr[31:24]) == $past(st_ff.mw1);
  endproperty
  a_mw1_claim: assert property (p_mw1_claim)
    else $error("window one claim without match");
  property p_mw2_claim;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_tgt_valid && !i_dac && i_tgt_type == PTB_ACC_MEM
      && i_tgt_addr[31:20] == st_ff.mw2) |=> o_claim_mw2;
  endproperty
  a_mw2_claim: assert property (p_mw2_claim)
    else $error("window two match not claimed");
  property p_no_dac;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_dac |=> !o_claim_mw1 && !o_claim_mw2 && !o_claim_io;
  endproperty
  a_no_dac: assert property (p_no_dac)
    else $error("dual address access claimed");
  property p_unmapped_rd;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_rd && sel == 3'h0) |=> o_rvalid && o_rdata == 32'h0000_0000;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd)
    else $error("unmapped read not zero");
  c_mw1: cover property (@(posedge i_clk) o_claim_mw1);
  c_mw2: cover property (@(posedge i_clk) o_claim_mw2);
  c_io: cover property (@(posedge i_clk) o_claim_io);
  c_cfg_wr: cover property (@(posedge i_clk) i_wr && i_cfg && sel != 3'h0);
endmodule
`default_nettype wire

// file: verification/ptb_host.sv
`default_nettype none
// ****************
// pci target side
// ****************
module ptb_host (
  input wire logic i_clk,
  output logic o_valid,
  output logic [1:0] o_type,
  output logic [31:0] o_addr,
  output logic o_dac
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    o_valid = 1'b0;
    o_type = 2'h0;
    o_addr = 32'h0;
    o_dac = 1'b0;
  end
  task automatic access(input logic [1:0] t, input logic [31:0] a,
                        input logic d);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_type <= t;
    o_addr <= a;
    o_dac <= d;
    @(posedge i_clk);
    o_valid <= 1'b0;
    // idle bus must not look like the last access
    o_addr <= ~a;
    o_type <= ~t;
  endtask
endmodule
`default_nettype wire

// file: verification/ptb_bar_regs_test.sv
`include "ptb_regs.svh"
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin \
  miscompares++; $display("Error %s exp %h got %h", n, e, s); end end
module ptb_bar_regs_test
  import ptb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 0, i_reset_n = 0, wr = 0, rd = 0, cfg = 0;
  logic [15:0] addr = 0;
  logic [31:0] wdata = 0, rdata, ta, r = 32'ha917, a;
  logic rvalid, c1, c2, cio, tv, td;
  logic [1:0] tt, t;
  logic [31:0] b [3];
  int miscompares = 0, n_tests = 0, k;
  logic [15:0] off [3] = '{`PTB_OFF_MW1_LOWER, `PTB_OFF_MW2_BASE,
                           `PTB_OFF_IO_BASE};
  logic [15:0] cof [3] = '{`PTB_CFG_MW1, `PTB_CFG_MW2, `PTB_CFG_IO};
  always #25 i_clk = ~i_clk;
  ptb_host host_u (.i_clk(i_clk), .o_valid(tv), .o_type(tt), .o_addr(ta),
    .o_dac(td));
  ptb_bar_regs dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_wr(wr),
    .i_rd(rd), .i_cfg(cfg), .i_addr(addr), .i_wdata(wdata), .i_dac(td),
    .i_tgt_valid(tv), .i_tgt_type(tt), .i_tgt_addr(ta), .o_rdata(rdata),
    .o_rvalid(rvalid), .o_claim_mw1(c1), .o_claim_mw2(c2), .o_claim_io(cio));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [31:0] mk(input int j);
    return j == 0 ? 32'hff000000 : j == 1 ? 32'hfff00000 : 32'hffffff00;
  endfunction
  function automatic logic [31:0] ex(input int j, input logic [31:0] v);
    return (v & mk(j)) | (j == 0 ? 32'h8 : j == 2 ? 32'h1 : 32'h0);
  endfunction
  task automatic wrt(input logic [15:0] o, input logic [31:0] d,
                     input logic c);
    @(posedge i_clk);
    wr <= 1'b1;
    addr <= o;
    wdata <= d;
    cfg <= c;
    @(posedge i_clk);
    wr <= 1'b0;
    cfg <= 1'b0;
  endtask
  task automatic rdc(input logic [15:0] o, input logic c,
                     input logic [31:0] e);
    @(posedge i_clk);
    rd <= 1'b1;
    addr <= o;
    cfg <= c;
    @(posedge i_clk);
    rd <= 1'b0;
    cfg <= 1'b0;
    #1;
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", e, rdata)
  endtask
  task automatic complete_run;
    $display("tests %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
    for (k = 0; k < 3; k++)
      rdc(off[k], 1'b0, ex(k, 0));
    $display("reset values done");
    for (k = 0; k < 3; k++)
    begin
      wrt(off[k], 32'hffffffff, 1'b0);
      rdc(cof[k], 1'b1, ex(k, '1));
      b[k] = ex(k, '1);
    end
    // upper registers only read, never written
    rdc(`PTB_OFF_MW0_UPPER, 1'b0, 32'h0);
    rdc(`PTB_OFF_MW1_UPPER, 1'b0, 32'h0);
    $display("masks done");
    // write and read back to back on window one
    @(posedge i_clk);
    wr <= 1'b1;
    addr <= off[0];
    wdata <= 32'h5a00_0000;
    @(posedge i_clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #1;
    `CHK("b2b rvalid", 1'b1, rvalid)
    `CHK("b2b rdata", ex(0, 32'h5a00_0000), rdata)
    b[0] = ex(0, 32'h5a00_0000);
    $display("back to back done");
    repeat (60)
    begin
      r = lfsr(r);
      k = r[1:0] % 3;
      b[k] = ex(k, r);
      wrt(off[k], r, 1'b0);
      r = lfsr(r);
      a = r[3] ? (b[k] & mk(k)) | (r & ~mk(k)) : r;
      t = r[5:4] == 2'h0 ? 2'h0 : (k == 2 ? PTB_ACC_IO : PTB_ACC_MEM);
      host_u.access(t, a, r[6] & r[7]);
      #1;
      `CHK("mw1", !td && t == 1 && a[31:24] == b[0][31:24], c1)
      `CHK("mw2", !td && t == 1 && a[31:20] == b[1][31:20], c2)
      `CHK("io", !td && t == 2 && a[31:8] == b[2][31:8], cio)
    end
    $display("decode done");
    // header offsets take writes as well
    for (k = 0; k < 3; k++)
    begin
      r = lfsr(r);
      b[k] = ex(k, r);
      wrt(cof[k], r, 1'b1);
      rdc(off[k], 1'b0, b[k]);
    end
    // write to an unmapped offset changes no base
    wrt(16'hd028, 32'hffff_ffff, 1'b0);
    for (k = 0; k < 3; k++)
      rdc(off[k], 1'b0, b[k]);
    $display("header writes done");
    // reset in mid-run clears every base
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    for (k = 0; k < 3; k++)
      rdc(off[k], 1'b0, ex(k, 0));
    $display("mid-run reset done");
    complete_run();
  end
  initial
  begin
    repeat (20000) @(posedge i_clk);
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
